// ---- inc/asa_map.vh ----
// register offsets, field positions and reset values of the alarm aggregator
`ifndef ASA_MAP_VH
`define ASA_MAP_VH

`define ASA_ADDR_W          12
`define ASA_OFF_SUMMARY     12'h2C0
`define ASA_OFF_FLAGS       12'h2C1
`define ASA_OFF_MASK        12'h2C2
`define ASA_OFF_LANE_LO     12'h2C4
`define ASA_OFF_LANE_HI     12'h2C5
`define ASA_OFF_PIN_SEL     12'h2C8
`define ASA_OFF_LINK_CTRL   12'h2C9

`define ASA_BIT_FIFO        5
`define ASA_BIT_PLL         4
`define ASA_BIT_LINK        3
`define ASA_BIT_REALIGN     2
`define ASA_BIT_OSC         1
`define ASA_BIT_CLK         0
`define ASA_BIT_SUMMARY     0

`define ASA_FLAGS_RESET     6'h3F
`define ASA_MASK_RESET      6'h3F
`define ASA_LANE_RESET      16'hFFFF
`define ASA_PIN_SEL_ALARM   1'b1

`endif

// ---- src/asa_alarm_status_aggregator.v ----
// alarm status aggregator: sticky alarm flags, mask, summary and interrupt pin
// Summary of operation
// R01 - summary bit 0 high while any flag is set with its mask clear
// R02 - pin selector routes the summary alarm onto the status output pin
// R03 - flag bit 5 set when any active lane FIFO overflows or underflows
// R04 - flag bit 4 set while the PLL reports not locked
// R05 - 8b/10b: flag bit 3 set while link enabled but not sending data
// R06 - 64b/66b: flag bit 3 set at link start-up and on any realignment while the link is enabled
// R07 - flag bit 2 set whenever a SYSREF event realigns the internal clocks
// R08 - flag bit 1 set on oscillator disable, sync, or A/B phase mismatch
// R09 - flag bit 0 set while channel A and B dividers disagree
// R10 - writing one clears a flag; writing zero leaves it alone
// R11 - power-on or soft reset sets all six flags, status reads 0x3F
// R12 - with link enable clear, all flags but the clock one are undefined
// R13 - software clears every flag after enabling the link, before trusting them
// R14 - six-bit mask, reset to all ones, hides flags from the summary
// R15 - per-lane FIFO flags, W1C per bit, wiped when the FIFO flag clears
// R16 - flags hold until cleared; a set in the clearing cycle wins
`timescale 1ns/100ps
`include "asa_map.vh"
module asa_alarm_status_aggregator #(
  parameter LANES = 16
) (
  input  wire                   clk_sys,
  input  wire                   rst,
  input  wire                   soft_reset,
  input  wire [`ASA_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_write,
  input  wire                   reg_read,
  output reg  [7:0]             reg_rdata,
  input  wire [LANES-1:0]       lane_active,
  input  wire [LANES-1:0]       lane_fifo_error,
  input  wire                   pll_locked,
  input  wire                   mode_64b66b,
  input  wire                   link_sending_data,
  input  wire                   link_realign_event,
  input  wire                   sysref_realign_event,
  input  wire                   osc_sync_event,
  input  wire                   osc_phase_mismatch,
  input  wire                   divider_mismatch,
  input  wire                   cal_status,
  output reg                    status_output_pin,
  output wire                   alarm_irq,
  output wire                   serial_link_enable
);
  localparam FLAG_W = 6;

  reg              link_en;
  reg              pin_sel;
  reg [FLAG_W-1:0] alarm_flag_mask;

  wire [FLAG_W-1:0] alarm_flags;
  wire [LANES-1:0]  per_lane_fifo_flags;
  wire              block_reset;
  wire              wr_flags;
  wire              wr_mask;
  wire              wr_lane_lo;
  wire              wr_lane_hi;
  wire              wr_pin_sel;
  wire              wr_link;
  wire              summary_alarm;
  wire [1:0]        rises;
  wire              link_start_pulse;
  wire              link_stop_pulse;
  wire [LANES-1:0]  lane_hits;
  wire [LANES-1:0]  lane_clear;
  wire [FLAG_W-1:0] flag_set;
  wire [FLAG_W-1:0] flag_clear;
  reg  [7:0]        next_rdata;

  // soft reset re-presets the flags exactly like power-on
  assign block_reset = rst | soft_reset; // R11

  assign wr_flags   = reg_write && (reg_addr == `ASA_OFF_FLAGS);
  assign wr_mask    = reg_write && (reg_addr == `ASA_OFF_MASK);
  assign wr_lane_lo = reg_write && (reg_addr == `ASA_OFF_LANE_LO);
  assign wr_lane_hi = reg_write && (reg_addr == `ASA_OFF_LANE_HI);
  assign wr_pin_sel = reg_write && (reg_addr == `ASA_OFF_PIN_SEL);
  assign wr_link    = reg_write && (reg_addr == `ASA_OFF_LINK_CTRL);

  always @(posedge clk_sys) begin
    if (block_reset) begin
      link_en         <= 1'b0;
      pin_sel         <= 1'b0;
      alarm_flag_mask <= `ASA_MASK_RESET; // R14
    end else begin
      if (wr_link) begin
        link_en <= reg_wdata[0];
      end
      if (wr_pin_sel) begin
        pin_sel <= reg_wdata[0];
      end
      if (wr_mask) begin
        alarm_flag_mask <= reg_wdata[FLAG_W-1:0]; // R14
      end
    end
  end

  assign serial_link_enable = link_en;

  asa_edge_detect #(
    .WIDTH (2)
  ) u_link_edges (
    .clk_sys  (clk_sys),
    .rst      (block_reset),
    .level_in ({~link_en, link_en}),
    .rise_out (rises)
  );
  assign link_start_pulse = rises[0];
  assign link_stop_pulse  = rises[1];

  // only lanes in use may raise a FIFO alarm
  assign lane_hits = lane_active & lane_fifo_error; // R03

  // lane flags: per-bit W1C, whole bank cleared with the FIFO status flag
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi = gi + 1) begin : g_lane_clr
      if (gi < 8) begin : g_lo
        assign lane_clear[gi] = (wr_lane_lo && reg_wdata[gi]) ||
                                (wr_flags && reg_wdata[`ASA_BIT_FIFO]); // R15
      end else begin : g_hi
        assign lane_clear[gi] = (wr_lane_hi && reg_wdata[gi-8]) ||
                                (wr_flags && reg_wdata[`ASA_BIT_FIFO]); // R15
      end
    end
  endgenerate

  asa_sticky_bits #(
    .WIDTH       (LANES),
    .RESET_VALUE ({LANES{1'b1}})
  ) u_lane_flags (
    .clk_sys  (clk_sys),
    .rst      (block_reset),
    .set_in   (lane_hits),
    .clear_in (lane_clear),
    .flags    (per_lane_fifo_flags)
  );

  assign flag_set[`ASA_BIT_FIFO] = |lane_hits; // R03
  assign flag_set[`ASA_BIT_PLL]  = ~pll_locked; // R04
  // 8b/10b: level condition; 64b/66b: start-up and realignment events
  assign flag_set[`ASA_BIT_LINK] = mode_64b66b ?
                                   (link_start_pulse | (link_en & link_realign_event)) : // R06
                                   (link_en & ~link_sending_data); // R05
  assign flag_set[`ASA_BIT_REALIGN] = sysref_realign_event; // R07
  // link disable also stops the oscillators
  assign flag_set[`ASA_BIT_OSC] = link_stop_pulse | ~link_en |
                                  osc_sync_event | osc_phase_mismatch; // R08
  assign flag_set[`ASA_BIT_CLK] = divider_mismatch; // R09

  // flags other than the clock one are meaningless while the link is off
  assign flag_clear = wr_flags ? reg_wdata[FLAG_W-1:0] : {FLAG_W{1'b0}}; // R10

  asa_sticky_bits #(
    .WIDTH       (FLAG_W),
    .RESET_VALUE (`ASA_FLAGS_RESET)
  ) u_flags (
    .clk_sys  (clk_sys),
    .rst      (block_reset),
    .set_in   (flag_set),
    .clear_in (flag_clear),
    .flags    (alarm_flags)
  ); // R11 R16 R12

  assign summary_alarm = |(alarm_flags & ~alarm_flag_mask); // R01 R14
  assign alarm_irq     = summary_alarm;

  always @(posedge clk_sys) begin
    if (block_reset) begin
      status_output_pin <= 1'b0;
    end else begin
      status_output_pin <= (pin_sel == `ASA_PIN_SEL_ALARM) ?
                           summary_alarm : cal_status; // R02
    end
  end

  always @* begin
    next_rdata = 8'h00;
    if (reg_addr == `ASA_OFF_SUMMARY) begin
      next_rdata[`ASA_BIT_SUMMARY] = summary_alarm; // R01
    end else if (reg_addr == `ASA_OFF_FLAGS) begin
      next_rdata[FLAG_W-1:0] = alarm_flags;
    end else if (reg_addr == `ASA_OFF_MASK) begin
      next_rdata[FLAG_W-1:0] = alarm_flag_mask;
    end else if (reg_addr == `ASA_OFF_LANE_LO) begin
      next_rdata = per_lane_fifo_flags[7:0]; // R15
    end else if (reg_addr == `ASA_OFF_LANE_HI) begin
      next_rdata = per_lane_fifo_flags[LANES-1:8]; // R15
    end else if (reg_addr == `ASA_OFF_PIN_SEL) begin
      next_rdata[0] = pin_sel;
    end else if (reg_addr == `ASA_OFF_LINK_CTRL) begin
      next_rdata[0] = link_en;
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// ---- src/asa_edge_detect.v ----
// rising-edge pulses for a bank of condition levels
`timescale 1ns/100ps
module asa_edge_detect #(
  parameter WIDTH = 2
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] level_in,
  output wire [WIDTH-1:0] rise_out
);
  reg [WIDTH-1:0] level_d;

  always @(posedge clk_sys) begin
    if (rst) begin
      // follow the level in reset so no false edge appears after release
      level_d <= level_in;
    end else begin
      level_d <= level_in;
    end
  end

  assign rise_out = level_in & ~level_d;
endmodule

// ---- src/asa_sticky_bits.v ----
// bank of write-one-to-clear sticky flags, set wins over clear
`timescale 1ns/100ps
module asa_sticky_bits #(
  parameter WIDTH = 6,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] set_in,
  input  wire [WIDTH-1:0] clear_in,
  output reg  [WIDTH-1:0] flags
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_sys) begin
        if (rst) begin
          flags[i] <= RESET_VALUE[i];
        end else if (set_in[i]) begin
          flags[i] <= 1'b1;
        end else if (clear_in[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// ---- verification/asa_alarm_status_aggregator_props.sv ----
// port assertions for the alarm aggregator
`timescale 1ns/100ps
`include "asa_map.vh"
module asa_props #(
  parameter LANES = 16
) (
  input wire                   clk_sys,
  input wire                   rst,
  input wire                   soft_reset,
  input wire [`ASA_ADDR_W-1:0] reg_addr,
  input wire [7:0]             reg_wdata,
  input wire                   reg_write,
  input wire                   reg_read,
  input wire [7:0]             reg_rdata,
  input wire [LANES-1:0]       lane_active,
  input wire [LANES-1:0]       lane_fifo_error,
  input wire                   pll_locked,
  input wire                   divider_mismatch,
  input wire                   cal_status,
  input wire                   status_output_pin,
  input wire                   alarm_irq,
  input wire                   serial_link_enable
);
  reg  pin_sel;
  wire pin_src = pin_sel ? alarm_irq : cal_status;
  wire rd_flags = reg_read && reg_addr == `ASA_OFF_FLAGS;
  wire pll_cond = !pll_locked && serial_link_enable;
  wire fifo_cond = serial_link_enable && |(lane_active & lane_fifo_error);
  // shadow of the pin selector, kept from observed writes
  always @(posedge clk_sys)
    if (rst || soft_reset) pin_sel <= 1'b0;
    else if (reg_write && reg_addr == `ASA_OFF_PIN_SEL) pin_sel <= reg_wdata[0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_summary_read: assert property (reg_read && reg_addr == `ASA_OFF_SUMMARY |=>
    reg_rdata == {7'h00, $past(alarm_irq)}) else $error("summary read wrong");
  a_pin_route: assert property (!soft_reset |=> status_output_pin == $past(pin_src))
    else $error("status pin wrong");
  a_fifo_flag: assert property (rd_flags && $past(fifo_cond) |=> reg_rdata[5])
    else $error("fifo flag missing");
  a_pll_flag: assert property (rd_flags && $past(pll_cond) |=> reg_rdata[4])
    else $error("pll flag missing");
  a_osc_off_flag: assert property (rd_flags && !$past(serial_link_enable) |=> reg_rdata[1])
    else $error("oscillator flag missing");
  a_clk_flag: assert property (rd_flags && $past(divider_mismatch) |=> reg_rdata[0])
    else $error("clock flag missing");
  a_mask_reset: assert property (soft_reset |=> !alarm_irq)
    else $error("irq after soft reset");
  a_irq_sticky: assert property (alarm_irq && !reg_write && !soft_reset |=> alarm_irq)
    else $error("irq dropped alone");
endmodule
bind asa_alarm_status_aggregator asa_props #(.LANES(LANES)) asa_props_inst (.clk_sys, .rst,
  .soft_reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .lane_active,
  .lane_fifo_error, .pll_locked, .divider_mismatch, .cal_status, .status_output_pin,
  .alarm_irq, .serial_link_enable);

// ---- verification/tb_asa_alarm_status_aggregator.sv ----
// self-checking bench of the alarm aggregator
`timescale 1ns/100ps
`include "asa_map.vh"
module tb_asa_alarm_status_aggregator;
  reg        clk_sys = 1'b0, rst = 1'b1, soft_reset = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  reg        pll_locked = 1'b1, mode_64b66b = 1'b0, link_sending_data = 1'b1, rd_q = 1'b0;
  reg        link_realign_event = 1'b0, sysref_realign_event = 1'b0, osc_sync_event = 1'b0;
  reg        osc_phase_mismatch = 1'b0, divider_mismatch = 1'b0, cal_status = 1'b0;
  reg [11:0] reg_addr = 12'h000;
  reg [7:0]  reg_wdata = 8'h00, f, m, w;
  reg [15:0] lane_active = 16'h0000, lane_fifo_error = 16'h0000, ln;
  reg [31:0] seed = 32'h8C65, cyc = 0;
  reg [7:0]  exp_q[$];
  wire [7:0] reg_rdata;
  wire       status_output_pin, alarm_irq, serial_link_enable;
  integer    num_errors = 0, checks = 0, i;
  asa_alarm_status_aggregator #(.LANES(16)) asa_alarm_status_aggregator_inst (.clk_sys, .rst,
    .soft_reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .lane_active,
    .lane_fifo_error, .pll_locked, .mode_64b66b, .link_sending_data, .link_realign_event,
    .sysref_realign_event, .osc_sync_event, .osc_phase_mismatch, .divider_mismatch,
    .cal_status, .status_output_pin, .alarm_irq, .serial_link_enable);
  always #10 clk_sys = ~clk_sys;
  function [31:0] xs(input [31:0] s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_read <= 1'b0;
    end
  endtask
  // conditions stay up until the next call, so a flag read sees them live
  task drive(input [4:0] c, input [15:0] err);
    begin
      @(posedge clk_sys);
      lane_fifo_error <= err;
      pll_locked <= !c[4];
      link_sending_data <= !c[3];
      sysref_realign_event <= c[2];
      osc_sync_event <= c[1] & seed[8];
      osc_phase_mismatch <= c[1] & !seed[8];
      divider_mismatch <= c[0];
      cal_status <= seed[9];
    end
  endtask
  always @(posedge clk_sys) begin
    rd_q <= reg_read;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  // read data stands only in the cycle after the strobe
  always @(negedge clk_sys) if (rd_q) check(reg_rdata, exp_q.pop_front());
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`ASA_OFF_FLAGS, 8'h3F);
    rd(`ASA_OFF_MASK, 8'h3F);
    rd(`ASA_OFF_LANE_HI, 8'hFF);
    rd(12'h2C3, 8'h00);
    wr(`ASA_OFF_LINK_CTRL, 8'h01);
    wr(`ASA_OFF_FLAGS, 8'h3F);
    rd(`ASA_OFF_LANE_LO, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      seed = xs(seed);
      lane_active <= seed[31:16];
      ln = seed[31:16] & seed[21:6] & {16{seed[7]}};
      f = {2'b00, |ln, seed[4:0]};
      m = {2'b00, seed[13:8]};
      w = {2'b00, seed[29:24]};
      drive(seed[4:0], seed[21:6] & {16{seed[7]}});
      wr(`ASA_OFF_MASK, m);
      wr(`ASA_OFF_PIN_SEL, {7'h00, seed[2]});
      rd(`ASA_OFF_FLAGS, f);
      drive(5'h00, 16'h0000);
      rd(`ASA_OFF_MASK, m);
      rd(`ASA_OFF_SUMMARY, {7'h00, |(f & ~m)});
      @(negedge clk_sys);
      #1;
      check({7'h00, alarm_irq}, {7'h00, |(f & ~m)});
      check({7'h00, status_output_pin}, {7'h00, seed[2] ? |(f & ~m) : seed[9]});
      rd(`ASA_OFF_LANE_LO, ln[7:0]);
      rd(`ASA_OFF_LANE_HI, ln[15:8]);
      wr(`ASA_OFF_FLAGS, w);
      rd(`ASA_OFF_FLAGS, f & ~w);
      wr(`ASA_OFF_FLAGS, 8'h3F);
    end
    divider_mismatch <= 1'b1;
    wr(`ASA_OFF_FLAGS, 8'h01);
    divider_mismatch <= 1'b0;
    rd(`ASA_OFF_FLAGS, 8'h01);
    mode_64b66b <= 1'b1;
    wr(`ASA_OFF_LINK_CTRL, 8'h00);
    wr(`ASA_OFF_LINK_CTRL, 8'h01);
    rd(`ASA_OFF_FLAGS, 8'h0B);
    wr(`ASA_OFF_FLAGS, 8'h3F);
    link_realign_event <= 1'b1;
    @(posedge clk_sys);
    link_realign_event <= 1'b0;
    rd(`ASA_OFF_FLAGS, 8'h08);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    rd(`ASA_OFF_FLAGS, 8'h3F);
    repeat (2) @(posedge clk_sys);
    test_done;
  end
endmodule
